// File: scs_pkg.sv
/*
 Shared constants, types and decode functions for the speech configuration
 supervisor. Assumes a single 40 MHz clock domain and an AXI4-Lite master.
*/
package scs_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 40_000_000; // System clock rate
  localparam int TICK_MS = 1; // Supervision tick period in ms
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS; // Tick at 4.000 MHz setting
  localparam int TICK_CYC_4096 = TICK_CYC * 4096 / 4000; // Tick at 4.096 MHz setting
  localparam int OSC_SW_US = 500; // Resonator stop to RC switch time
  localparam int OSC_SW_CYC = CLK_HZ / 1_000_000 * OSC_SW_US;
  localparam int CMD_BUSY_NS = 1000; // Busy time after each command
  localparam logic [5:0] CMD_BUSY_CYC = 6'(CMD_BUSY_NS * (CLK_HZ / 1_000_000) / 1000);
  // Overflow periods in ms
  localparam logic [11:0] OVF_125_MS = 12'h07D;
  localparam logic [11:0] OVF_500_MS = 12'h1F4;
  localparam logic [11:0] OVF_2_S = 12'h7D0;
  localparam logic [11:0] OVF_4_S = 12'hFA0;
  // ==========================================================
  // Stored configuration layout
  localparam logic [7:0] PROT_BLOCK = 8'h69; // Blocks direct flash access
  localparam int CFG_CLK_BIT = 0; // 1 = RC oscillator
  localparam int CFG_FRQ_BIT = 1; // 1 = 4.096 MHz
  localparam int CFG_PHR_LSB = 2; // Two bits of phrase count
  localparam int CFG_RET_BIT = 4; // 1 = return to post power-up state
  localparam int CFG_OVF_LSB = 5; // Two bits of overflow period
  localparam logic [1:0] LD_PROT = 2'h0;
  localparam logic [1:0] LD_CFG = 2'h1;
  localparam logic [1:0] LD_INFO = 2'h2;
  localparam logic [12:0] PHR_4096 = 13'h1000;
  localparam logic [12:0] PHR_3072 = 13'h0C00;
  localparam logic [12:0] PHR_2048 = 13'h0800;
  localparam logic [12:0] PHR_1024 = 13'h0400;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_CFG = 8'h08;
  localparam logic [7:0] REG_SAFE = 8'h0C;
  localparam logic [7:0] REG_ERR = 8'h10;
  localparam logic [7:0] REG_GRP = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Command opcodes in CMD[7:0], argument in CMD[15:8]
  localparam logic [7:0] OP_PUP = 8'h01;
  localparam logic [7:0] OP_POWER_DOWN_CMD = 8'h02;
  localparam logic [7:0] OP_ANALOG_MODE_CMD = 8'h03;
  localparam logic [7:0] OP_DIRECT_FLASH_ACCESS_CMD = 8'h04;
  localparam logic [7:0] OP_ERROR_READ_CMD = 8'h05;
  localparam logic [7:0] OP_KICK = 8'h06;
  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    ST_LOAD = 4'h1, ST_PDOWN = 4'h2, ST_READY = 4'h4, ST_ACTIVE = 4'h8
  } scs_state_t;
  typedef struct packed {
    logic [7:0] prot; logic clk_rc; logic f4096; logic [1:0] phr;
    logic ovf_ret; logic [1:0] ovf_sel;
  } scs_cfg_t;
  typedef struct packed {
    logic fs_mix; logic rst_ovf; logic wdt_ovf; logic spk_short;
    logic osc_fail; logic flash_err;
  } scs_err_t;
  typedef struct packed {
    logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata;
    logic [3:0] wstrb; logic bready; logic arvalid; logic [7:0] araddr;
    logic rready;
  } scs_axi_req_t;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } scs_axi_rsp_t;
  // ==========================================================
  // Decoders
  function automatic logic [11:0] ovf_ms(input logic [1:0] sel);
    logic [11:0] r;
    unique case (sel)
      2'h0: r = OVF_125_MS;
      2'h1: r = OVF_500_MS;
      2'h2: r = OVF_2_S;
      default: r = OVF_4_S;
    endcase
    return r;
  endfunction
  function automatic logic [12:0] phr_count(input logic [1:0] sel);
    logic [12:0] r;
    unique case (sel)
      2'h0: r = PHR_4096;
      2'h1: r = PHR_3072;
      2'h2: r = PHR_2048;
      default: r = PHR_1024;
    endcase
    return r;
  endfunction
  function automatic logic reg_hit(input logic [7:0] a);
    return a inside {REG_CMD, REG_STAT, REG_CFG, REG_SAFE, REG_ERR, REG_GRP};
  endfunction
endpackage

// File: scs_sync.sv
/*
 Three-stage input synchroniser for one asynchronous pin.
 The output moves only when the second and third stages agree.
*/
`timescale 1ns/1ps
module scs_sync import scs_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pin,
  output logic q
);
  // ==========================================================
  // State
  typedef struct packed {
    logic s1; logic s2; logic s3; logic o;
  } scs_sync_t;
  scs_sync_t s_r, s_nxt;

  // Shift, then accept the level once the last two stages agree
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = pin;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    if (s_r.s2 == s_r.s3) begin
      s_nxt.o = s_r.s3;
    end
  end

  // Register the whole state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.o;
endmodule // scs_sync

// File: scs_ovf_timer.sv
/*
 Supervision overflow timer: a millisecond prescaler whose length follows the
 declared master clock, then a millisecond counter against the chosen period.
 Assumes run and clr come from logic on the same clock.
*/
`timescale 1ns/1ps
module scs_ovf_timer import scs_pkg::*; #(
  parameter int TICK_A = TICK_CYC,
  parameter int TICK_B = TICK_CYC_4096
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic clr,
  input wire logic f4096,
  input wire logic [1:0] sel,
  output logic ovf
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [15:0] pre; logic [11:0] ms; logic ovf;
  } scs_tmr_t;
  scs_tmr_t t_r, t_nxt;
  logic [15:0] tick_last; // Last prescaler count

  // Prescaler and period counter; overflow is a one-cycle pulse
  always_comb begin
    t_nxt = t_r;
    t_nxt.ovf = 1'b0;
    tick_last = f4096 ? 16'(TICK_B - 1) : 16'(TICK_A - 1);
    if (!run || clr) begin
      // Stopped or kicked: restart the whole period
      t_nxt.pre = '0;
      t_nxt.ms = '0;
    end else if (t_r.pre == tick_last) begin
      t_nxt.pre = '0;
      if (t_r.ms == ovf_ms(sel) - 12'h001) begin
        t_nxt.ms = '0;
        t_nxt.ovf = 1'b1;
      end else begin
        t_nxt.ms = t_r.ms + 12'h001;
      end
    end else begin
      t_nxt.pre = t_r.pre + 16'h0001;
    end
  end

  // Register the whole state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end

  assign ovf = t_r.ovf;
endmodule // scs_ovf_timer

// File: scs_top.sv
/*
 Speech configuration supervisor: loads the stored configuration from flash,
 gates host commands with busy, guards direct flash access and supervises the
 watchdog, resonator, speaker short and flash error events.
 Assumes an AXI4-Lite master on clk and a same-clock flash byte reader.
*/
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
// Contract
// - Blocking code refuses every direct flash access
// - Otherwise grant only on matching unlock byte
// - Configuration selects RC or resonator clock; clk_use_rc is set only by the resonator-stop fallback
// - Declared frequency sets internal timing
// - Configuration fixes phrase count, four sizes
// - Class D output is half-wave only
// - Overflow holds or returns to post power-up
// - Overflow period is 125ms, 500ms, 2s, 4s
// - Class D use reports clamp or short
// - Channels outside selected rate group flagged
// - Error read waits out oscillator switchover
// - Both enables written: only reset counter set
// - Supervision enable resets to zero
`timescale 1ns/1ps
module scs_top import scs_pkg::*; #(
  parameter int TICK_CYC_4000 = TICK_CYC,
  parameter int TICK_CYC_4K096 = TICK_CYC_4096,
  parameter int OSC_SW_CYCLES = OSC_SW_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire scs_axi_req_t axi_i,
  output scs_axi_rsp_t axi_o,
  output logic flash_rd_req,
  output logic [1:0] flash_rd_addr,
  input wire logic flash_rd_ack,
  input wire logic [7:0] flash_rd_data,
  input wire logic flash_err_in,
  input wire logic osc_stop_pin,
  input wire logic speaker_short_pin,
  input wire logic flash_path_select_pin,
  input wire logic clamp_in,
  input wire logic [3:0] ch_active,
  input wire logic [7:0] ch_fs_group,
  output logic command_busy_low,
  output logic clk_use_rc,
  output logic [12:0] phrase_limit,
  output logic class_d_half_wave,
  output logic amp_class_d_en,
  output logic analog_up,
  output logic direct_flash_en
);
  // ==========================================================
  // State of the block
  typedef struct packed {
    scs_state_t st; logic [1:0] ld_idx; logic rd_req;
    scs_cfg_t cfg; logic [7:0] rom_info; logic [12:0] phr_lim;
    logic [5:0] busy_cnt; logic busy_n; logic rd_hold;
    logic sup_en; logic wdt_en; logic rst_en;
    logic [1:0] fs_sel; logic [3:0] fs_mis; scs_err_t err;
    logic dir_mode; logic dir_refused; logic cmd_rej;
    logic class_d; logic ana_up; logic half_wave;
    logic [15:0] osc_cnt; logic osc_pend; logic on_rc;
    logic aw_got; logic w_got; logic [7:0] awaddr; logic [31:0] wdata;
    logic [3:0] wstrb; scs_axi_rsp_t rsp;
  } scs_st_t;
  scs_st_t s_r, s_nxt;

  logic osc_stop_s; // Synchronised resonator stop
  logic spk_short_s; // Synchronised speaker short
  logic path_sel_s; // Synchronised flash path select
  logic ovf; // Supervision overflow pulse
  logic tmr_run; // Supervision counter running
  logic tmr_clr; // Supervision counter kick
  logic [3:0] mis; // Channels outside the selected group
  logic do_wr; // Register write completes this cycle
  logic cmd_ok; // Accepted host command
  logic [7:0] op; // Command opcode
  logic [7:0] arg; // Command argument
  scs_err_t err_set; // Hardware events this cycle
  scs_err_t err_clr; // Software clears this cycle

  // ==========================================================
  // Pin synchronisers
  logic [2:0] pins;
  logic [2:0] pins_s;
  assign pins = {flash_path_select_pin, speaker_short_pin, osc_stop_pin};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      scs_sync u_sync (.clk(clk), .nrst(nrst), .pin(pins[gi]), .q(pins_s[gi]));
    end
  endgenerate
  assign osc_stop_s = pins_s[0];
  assign spk_short_s = pins_s[1];
  assign path_sel_s = pins_s[2];

  // Channels playing outside the selected rate group
  generate
    for (gi = 0; gi < 4; gi++) begin : g_fs
      assign mis[gi] = ch_active[gi] && (ch_fs_group[2*gi+:2] != s_r.fs_sel);
    end
  endgenerate

  // ==========================================================
  // Supervision timer; only one of the two counters is ever enabled
  assign tmr_run = s_r.sup_en && (s_r.wdt_en || s_r.rst_en)
                   && (s_r.st inside {ST_READY, ST_ACTIVE});
  assign tmr_clr = cmd_ok && (s_r.wdt_en || op == OP_KICK);
  scs_ovf_timer #(.TICK_A(TICK_CYC_4000), .TICK_B(TICK_CYC_4K096)) u_tmr (
    .clk(clk), .nrst(nrst), .run(tmr_run), .clr(tmr_clr),
    .f4096(s_r.cfg.f4096), .sel(s_r.cfg.ovf_sel), .ovf(ovf)
  );

  // ==========================================================
  // Next-state logic
  assign do_wr = s_r.aw_got && s_r.w_got && !s_r.rsp.bvalid;
  assign op = s_r.wdata[7:0];
  assign arg = s_r.wdata[15:8];
  // Commands written while busy is low are refused, not queued
  assign cmd_ok = do_wr && s_r.awaddr == REG_CMD && s_r.wstrb[1:0] == 2'h3
                  && s_r.busy_n;

  always_comb begin
    s_nxt = s_r;
    err_set = '0;
    err_clr = '0;
    // AXI write address and data are taken in either order
    if (axi_i.awvalid && s_r.rsp.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = axi_i.awaddr;
    end
    if (axi_i.wvalid && s_r.rsp.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = axi_i.wdata;
      s_nxt.wstrb = axi_i.wstrb;
    end
    if (s_r.rsp.bvalid && axi_i.bready) begin
      s_nxt.rsp.bvalid = 1'b0;
    end
    // Register write with its side effects
    if (do_wr) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.rsp.bvalid = 1'b1;
      s_nxt.rsp.bresp = reg_hit(s_r.awaddr) ? RESP_OKAY : RESP_DECERR;
      if (s_r.wstrb[0]) begin
        if (s_r.awaddr == REG_SAFE) begin
          s_nxt.sup_en = s_r.wdata[0];
          s_nxt.wdt_en = s_r.wdata[1] && !s_r.wdata[2];
          s_nxt.rst_en = s_r.wdata[2];
        end
        if (s_r.awaddr == REG_ERR) begin
          err_clr = s_r.wdata[5:0];
        end
        if (s_r.awaddr == REG_GRP) begin
          s_nxt.fs_sel = s_r.wdata[1:0];
        end
      end
      if (s_r.awaddr == REG_CMD) begin
        s_nxt.cmd_rej = !cmd_ok;
      end
    end
    // Command execution
    if (cmd_ok) begin
      s_nxt.busy_cnt = CMD_BUSY_CYC;
      unique case (op)
        OP_PUP: begin
          if (s_r.st == ST_PDOWN) begin
            s_nxt.st = ST_READY;
          end
        end
        OP_POWER_DOWN_CMD: begin
          s_nxt.st = ST_PDOWN;
          s_nxt.class_d = 1'b0;
          s_nxt.ana_up = 1'b0;
        end
        OP_ANALOG_MODE_CMD: begin
          if (s_r.st != ST_PDOWN) begin
            s_nxt.class_d = arg[0];
            s_nxt.ana_up = arg[1];
            s_nxt.st = arg[1] ? ST_ACTIVE : ST_READY;
          end
        end
        OP_DIRECT_FLASH_ACCESS_CMD: begin
          // Only after power-up; the mode lasts until the next reset
          if (s_r.st != ST_PDOWN) begin
            if (s_r.cfg.prot != PROT_BLOCK && arg == s_r.cfg.prot) begin
              s_nxt.dir_mode = 1'b1;
            end else begin
              s_nxt.dir_refused = 1'b1;
            end
          end
        end
        OP_ERROR_READ_CMD: begin
          // Keep busy low until the clock switchover has settled
          s_nxt.rd_hold = s_r.osc_pend;
        end
        default: begin
          s_nxt.cmd_rej = (op != OP_KICK);
        end
      endcase
    end else if (s_r.busy_cnt != 6'h00) begin
      s_nxt.busy_cnt = s_r.busy_cnt - 6'h01;
    end
    // Configuration load from flash before any command
    if (s_r.st == ST_LOAD && flash_rd_ack) begin
      unique case (s_r.ld_idx)
        LD_PROT: s_nxt.cfg.prot = flash_rd_data;
        LD_CFG: begin
          s_nxt.cfg.clk_rc = flash_rd_data[CFG_CLK_BIT];
          s_nxt.cfg.f4096 = flash_rd_data[CFG_FRQ_BIT];
          s_nxt.cfg.phr = flash_rd_data[CFG_PHR_LSB+:2];
          s_nxt.phr_lim = phr_count(flash_rd_data[CFG_PHR_LSB+:2]);
          s_nxt.cfg.ovf_ret = flash_rd_data[CFG_RET_BIT];
          s_nxt.cfg.ovf_sel = flash_rd_data[CFG_OVF_LSB+:2];
        end
        default: s_nxt.rom_info = flash_rd_data;
      endcase
      if (s_r.ld_idx == LD_INFO) begin
        s_nxt.rd_req = 1'b0;
        s_nxt.st = ST_PDOWN;
      end else begin
        s_nxt.ld_idx = s_r.ld_idx + 2'h1;
      end
    end
    // Full-wave is never offered; the stored format bit is ignored
    s_nxt.half_wave = 1'b1;
    // Resonator stop: count the settle time, then fall back to RC
    if (!s_r.cfg.clk_rc && !s_r.on_rc && osc_stop_s && s_r.st != ST_LOAD) begin
      s_nxt.osc_pend = 1'b1;
      if (s_r.osc_cnt == 16'(OSC_SW_CYCLES - 1)) begin
        s_nxt.osc_cnt = '0;
        s_nxt.osc_pend = 1'b0;
        s_nxt.on_rc = 1'b1;
        err_set.osc_fail = 1'b1;
      end else begin
        s_nxt.osc_cnt = s_r.osc_cnt + 16'h0001;
      end
    end else begin
      s_nxt.osc_cnt = '0;
      s_nxt.osc_pend = 1'b0;
    end
    if (!s_nxt.osc_pend) begin
      s_nxt.rd_hold = 1'b0;
    end
    // With return on overflow selected, supervision overflow wins over a command in the same cycle
    if (ovf) begin
      err_set.wdt_ovf = s_r.wdt_en;
      err_set.rst_ovf = s_r.rst_en;
      if (s_r.cfg.ovf_ret) begin
        s_nxt.st = ST_READY;
        s_nxt.class_d = 1'b0;
        s_nxt.ana_up = 1'b0;
      end
    end
    // Short detection stays armed whenever class D is enabled and the analog path is up
    err_set.spk_short = s_r.class_d && s_r.ana_up && (spk_short_s || clamp_in);
    err_set.flash_err = flash_err_in;
    err_set.fs_mix = |mis;
    s_nxt.fs_mis = mis;
    // Set wins over a clear in the same cycle
    s_nxt.err = (s_r.err & ~err_clr) | err_set;
    // Busy is low while loading, counting or holding an error read
    s_nxt.busy_n = s_nxt.st != ST_LOAD && s_nxt.busy_cnt == 6'h00
                   && !s_nxt.rd_hold;
    s_nxt.rsp.awready = !s_nxt.aw_got && !s_nxt.rsp.bvalid;
    s_nxt.rsp.wready = !s_nxt.w_got && !s_nxt.rsp.bvalid;
    // Read channel: one answer per address, held until rready
    if (s_r.rsp.rvalid && axi_i.rready) begin
      s_nxt.rsp.rvalid = 1'b0;
    end
    if (axi_i.arvalid && s_r.rsp.arready) begin
      s_nxt.rsp.rvalid = 1'b1;
      s_nxt.rsp.rresp = reg_hit(axi_i.araddr) ? RESP_OKAY : RESP_DECERR;
      unique case (axi_i.araddr)
        REG_STAT: s_nxt.rsp.rdata = {18'h00000, path_sel_s, s_r.on_rc, s_r.osc_pend,
                                     s_r.cmd_rej, s_r.dir_refused, s_r.dir_mode,
                                     s_r.ana_up, s_r.class_d, s_r.busy_n, s_r.st, s_r.half_wave};
        REG_CFG: s_nxt.rsp.rdata = {s_r.rom_info, s_r.cfg.prot, 1'b0, s_r.cfg};
        REG_SAFE: s_nxt.rsp.rdata = {29'h00000000, s_r.rst_en, s_r.wdt_en, s_r.sup_en};
        REG_ERR: s_nxt.rsp.rdata = {26'h0000000, s_r.err};
        REG_GRP: s_nxt.rsp.rdata = {17'h00000, s_r.phr_lim[12:10], s_r.fs_mis, 4'h0,
                                    2'h0, s_r.fs_sel};
        default: s_nxt.rsp.rdata = 32'h00000000;
      endcase
    end
    s_nxt.rsp.arready = !s_nxt.rsp.rvalid;
  end

  // Register the whole state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.st <= ST_LOAD;
      s_r.rd_req <= 1'b1;
      s_r.phr_lim <= PHR_4096;
      s_r.rsp.awready <= 1'b1;
      s_r.rsp.wready <= 1'b1;
      s_r.rsp.arready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  assign axi_o = s_r.rsp;
  assign flash_rd_req = s_r.rd_req;
  assign flash_rd_addr = s_r.ld_idx;
  assign command_busy_low = s_r.busy_n;
  assign clk_use_rc = s_r.on_rc;
  assign phrase_limit = s_r.phr_lim;
  assign class_d_half_wave = s_r.half_wave;
  assign amp_class_d_en = s_r.class_d;
  assign analog_up = s_r.ana_up;
  assign direct_flash_en = s_r.dir_mode;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence osc_settled;
    s_r.osc_pend ##1 s_r.on_rc;
  endsequence
  a_prot_block: assert property (s_r.cfg.prot == PROT_BLOCK |=> !$rose(s_r.dir_mode))
    else $error("direct access granted under blocking code");
  a_unlock_match: assert property ($rose(s_r.dir_mode) |-> $past(arg) == s_r.cfg.prot)
    else $error("direct access granted without matching unlock");
  a_half_only: assert property (s_r.st != ST_LOAD |-> s_r.half_wave)
    else $error("class D format not half-wave");
  a_ovf_return: assert property (ovf && s_r.cfg.ovf_ret |=> s_r.st == ST_READY)
    else $error("overflow did not return to post power-up state");
  a_enable_pair: assert property (!(s_r.wdt_en && s_r.rst_en))
    else $error("both supervision enables set");
  a_sup_cause: assert property ($rose(s_r.sup_en) |-> $past(do_wr) && $past(s_r.awaddr) == REG_SAFE)
    else $error("supervision enabled without a write");
  a_load_busy: assert property (s_r.st == ST_LOAD |-> !command_busy_low ##0 !cmd_ok)
    else $error("busy high during configuration load");
  a_short_flag: assert property (s_r.class_d && s_r.ana_up && clamp_in |=> s_r.err.spk_short)
    else $error("clamp not reported as speaker short");
  a_error_read_cmd_hold: assert property (s_r.rd_hold |-> !command_busy_low)
    else $error("busy released during oscillator switchover");
  a_osc_switch: assert property (osc_settled |=> s_r.err.osc_fail)
    else $error("oscillator fail not flagged at switchover");
endmodule // scs_top

// File: scs_flash_model.sv
/*
 Behavioural stored-configuration flash reader for the supervisor bench.
 Assumes the same clock as the design and a held byte request.
*/
`timescale 1ns/1ps
module scs_flash_model #(
  parameter int LAT = 3
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req,
  input wire logic [1:0] addr,
  input wire logic [7:0] prot,
  input wire logic [7:0] cfg,
  input wire logic [7:0] info,
  output logic ack,
  output logic [7:0] data
);
  // ==========================================================
  // Byte server
  int cnt; // Wait states before each answer
  // Slow answer; data toggles outside ack so a stale byte never looks valid
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      ack <= 1'b0;
      data <= 8'hFF;
    end else begin
      ack <= 1'b0;
      data <= ~data;
      if (req && !ack) begin
        if (cnt == LAT) begin
          cnt <= 0;
          ack <= 1'b1;
          data <= (addr == 2'h0) ? prot : (addr == 2'h1) ? cfg : info;
        end else begin
          cnt <= cnt + 1;
        end
      end
    end
  end
endmodule // scs_flash_model

// File: speech_config_supervisor_tb.sv
/*
 Self-checking bench for the supervisor over its AXI4-Lite port.
 Assumes a 40 MHz clock and the flash reader model beside the design.
*/
`timescale 1ns/1ps
module speech_config_supervisor_tb;
  import scs_pkg::*;
  // ==========================================================
  // Signals
  logic clk = 1'b0;
  logic nrst = 1'b0;
  scs_axi_req_t axi_i = '0;
  scs_axi_rsp_t axi_o;
  logic rq, ack, clamp_in = 1'b0;
  logic [1:0] ra;
  logic [7:0] rdat, prot = 8'h5A;
  logic flash_err = 1'b0, osc_stop = 1'b0, spk_pin = 1'b0, path_sel = 1'b0;
  logic [3:0] ch_act = 4'h0;
  logic [7:0] ch_grp = 8'h00, cfg_b = 8'h4D;
  logic [31:0] d;
  logic [1:0] r;
  int bad_count = 0;
  int compares = 0;
  always #12.5 clk = ~clk;
  // Switchover longer than the command busy time, so the error-read hold is visible
  scs_top #(.TICK_CYC_4000(4), .TICK_CYC_4K096(5), .OSC_SW_CYCLES(60)) u_dut (
    .clk(clk), .nrst(nrst), .axi_i(axi_i), .axi_o(axi_o), .flash_rd_req(rq),
    .flash_rd_addr(ra), .flash_rd_ack(ack), .flash_rd_data(rdat), .flash_err_in(flash_err),
    .osc_stop_pin(osc_stop), .speaker_short_pin(spk_pin), .flash_path_select_pin(path_sel),
    .clamp_in(clamp_in), .ch_active(ch_act), .ch_fs_group(ch_grp), .command_busy_low(),
    .clk_use_rc(), .phrase_limit(), .class_d_half_wave(), .amp_class_d_en(),
    .analog_up(), .direct_flash_en());
  // Config byte: RC, 4.000 MHz, 1024 phrases, hold, 2 s
  scs_flash_model u_flash (.clk(clk), .nrst(nrst), .req(rq), .addr(ra), .prot(prot),
    .cfg(cfg_b), .info(8'hC3), .ack(ack), .data(rdat));
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Write; readies are sampled on the falling edge so no race with the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w, b;
    @(posedge clk);
    axi_i.awvalid <= 1'b1;
    axi_i.awaddr <= a;
    axi_i.wvalid <= 1'b1;
    axi_i.wdata <= v;
    axi_i.wstrb <= 4'hF;
    axi_i.bready <= 1'b1;
    do begin
      @(negedge clk);
      aw = axi_o.awready;
      w = axi_o.wready;
      b = axi_o.bvalid;
      r = axi_o.bresp;
      @(posedge clk);
      if (aw) axi_i.awvalid <= 1'b0;
      if (w) axi_i.wvalid <= 1'b0;
    end while (b !== 1'b1);
    axi_i.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar, v;
    @(posedge clk);
    axi_i.arvalid <= 1'b1;
    axi_i.araddr <= a;
    axi_i.rready <= 1'b1;
    do begin
      @(negedge clk);
      ar = axi_o.arready;
      v = axi_o.rvalid;
      d = axi_o.rdata;
      r = axi_o.rresp;
      @(posedge clk);
      if (ar) axi_i.arvalid <= 1'b0;
    end while (v !== 1'b1);
    axi_i.rready <= 1'b0;
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (u_dut.command_busy_low !== 1'b1 && n < 500);
  endtask
  task automatic boot(input logic [7:0] p, input logic [7:0] c);
    prot <= p;
    cfg_b <= c;
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    wait_ready;
  endtask
  task automatic end_sim;
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // Watchdog: the sequence needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_sim;
  end
  // ==========================================================
  // Tests
  initial begin
    boot(8'h5A, 8'h4D);
    chk(u_dut.command_busy_low, 1);
    rd(REG_CFG);
    chk(d[31:16], 32'hC35A);
    chk(d[6:0], 32'h5A);
    chk(u_dut.phrase_limit, PHR_1024);
    chk(u_dut.class_d_half_wave, 1);
    rd(REG_SAFE);
    chk(d[2:0], 0);
    wr(REG_SAFE, 32'h6);
    rd(REG_SAFE);
    chk(d[2:0], 32'h4);
    rd(8'h40);
    chk(r, RESP_DECERR);
    wr(REG_CMD, {24'h0, OP_PUP});
    wait_ready;
    wr(REG_CMD, {16'h0, 8'h03, OP_ANALOG_MODE_CMD});
    clamp_in <= 1'b1;
    wait_ready;
    rd(REG_ERR);
    chk(d[2], 1);
    clamp_in <= 1'b0;
    // Flash error pulse, reprogramming path, channel 1 outside rate group 0
    flash_err <= 1'b1;
    path_sel <= 1'b1;
    ch_act <= 4'h2;
    ch_grp <= 8'h04;
    @(posedge clk);
    flash_err <= 1'b0;
    repeat (5) @(posedge clk);
    rd(REG_STAT);
    chk(d[13], 1);
    rd(REG_GRP);
    chk(d[14:0], 32'h1200);
    // Clearing both: flash error goes, the standing mismatch sets again
    wr(REG_ERR, 32'h21);
    rd(REG_ERR);
    chk(d[5:0], 32'h24);
    ch_act <= 4'h0;
    path_sel <= 1'b0;
    wr(REG_CMD, {16'h0, 8'h5B, OP_DIRECT_FLASH_ACCESS_CMD});
    wait_ready;
    rd(REG_STAT);
    chk(d[9:8], 32'h2);
    wr(REG_CMD, {16'h0, 8'h5A, OP_DIRECT_FLASH_ACCESS_CMD});
    wait_ready;
    chk(u_dut.direct_flash_en, 1);
    // Second command lands inside the first one's busy time
    wr(REG_CMD, {24'h0, OP_ERROR_READ_CMD});
    wr(REG_CMD, {24'h0, OP_KICK});
    rd(REG_STAT);
    chk(d[10], 1);
    // Resonator, 4.096 MHz, 4096 phrases, return on overflow, 125 ms
    boot(PROT_BLOCK, 8'h12);
    rd(REG_SAFE);
    chk(d[2:0], 0);
    rd(REG_CFG);
    chk(d[6:0], 32'h24);
    wr(REG_CMD, {24'h0, OP_PUP});
    wait_ready;
    wr(REG_CMD, {16'h0, PROT_BLOCK, OP_DIRECT_FLASH_ACCESS_CMD});
    wait_ready;
    rd(REG_STAT);
    chk(d[9:8], 32'h2);
    chk(u_dut.direct_flash_en, 0);
    // Watchdog on; overflow 625 cycles after the last accepted command
    wr(REG_SAFE, 32'h3);
    wr(REG_CMD, {16'h0, 8'h03, OP_ANALOG_MODE_CMD});
    spk_pin <= 1'b1;
    repeat (600) @(posedge clk);
    rd(REG_ERR);
    chk(d[4:2], 32'h1);
    repeat (30) @(posedge clk);
    rd(REG_ERR);
    chk(d[4:2], 32'h3);
    rd(REG_STAT);
    chk(d[7:1], 32'h14);
    // Resonator stops; an error read during the switchover keeps busy low
    osc_stop <= 1'b1;
    repeat (4) @(posedge clk);
    wr(REG_CMD, {24'h0, OP_ERROR_READ_CMD});
    repeat (45) @(negedge clk);
    chk(u_dut.command_busy_low, 0);
    wait_ready;
    rd(REG_ERR);
    chk(d[1], 1);
    chk(u_dut.clk_use_rc, 1);
    wr(REG_CMD, {24'h0, OP_POWER_DOWN_CMD});
    rd(REG_STAT);
    chk(d[4:1], 32'h2);
    end_sim;
  end
endmodule // speech_config_supervisor_tb
